// ### ltmf_cell.sv
/*
  LIN transceiver mode and fault control cell: mode selection per chip
  mode, slope, bus wake detection, transmit time-out, bus dominant clamp,
  transmit/receive short and over-temperature recovery.
  Assumes synchronous pin inputs and an SPI decoder issuing one-cycle
  command strobes.
*/
`timescale 1ns/100ps
module ltmf_cell (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Chip mode
  input wire logic [2:0] chip_mode,
  // SPI command strobes
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic slope_cmd_valid,
  input wire logic slope_normal_sel,
  input wire logic wake_flag_clear,
  input wire logic bus_fault_clear,
  input wire logic short_fault_clear,
  input wire logic wake_irq_mask,
  input wire logic bus_fault_irq_mask,
  input wire logic [2:0] spi_read_addr,
  // Host pins and bus
  input wire logic txd_in,
  input wire logic lin_bus_line,
  input wire logic over_temp,
  output logic rxd_out,
  output logic int_n,
  // Transceiver controls
  output logic bus_drive_dominant,
  output logic pullup_en,
  output logic slope_normal,
  output logic slope_ctrl_off,
  output logic restart_req,
  // Status to SPI
  output logic [2:0] lin_mode,
  output logic lin_wake_flag,
  output logic bus_fault_flag,
  output logic short_fault_flag,
  output logic tx_timeout_flag,
  output logic [7:0] spi_read_data
);

  ltmf_pkg::ltmf_mode_e mode_r;
  ltmf_pkg::ltmf_mode_e mode_nxt;
  logic slope_r;
  logic wake_flag_r;
  logic wake_rxd_low_r;
  logic wake_lock_r;
  logic bus_fault_r;
  logic short_r;
  logic tx_to_r;
  logic ot_block_r;
  logic txd_prev_r;
  logic bus_prev_r;
  logic wake_armed_r;
  logic [7:0] read_data_r;
  logic rxd_r;
  logic drive_r;
  logic int_n_r;
  logic tx_expired;
  logic bus_expired;
  logic wake_filtered;
  logic wake_event;
  logic cmd_normal;
  logic fault_any;
  logic tx_allowed;

  assign cmd_normal = cmd_valid && (cmd_code == ltmf_pkg::CMD_NORMAL);

  ////////////////////////////////////////////////////////////////////////
  // Timers

  ltmf_timer #(.LIMIT(ltmf_pkg::TX_TIMEOUT_CYC)) u_tx_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .level_active(!txd_in && (mode_r == ltmf_pkg::LTMF_NORMAL)),
    .expired(tx_expired)
  );

  ltmf_timer #(.LIMIT(ltmf_pkg::BUS_TIMEOUT_CYC)) u_bus_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .level_active(!lin_bus_line && (mode_r == ltmf_pkg::LTMF_NORMAL)),
    .expired(bus_expired)
  );

  ltmf_timer #(.LIMIT(ltmf_pkg::WAKE_FILTER_CYC)) u_wake_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .level_active(!lin_bus_line && (mode_r == ltmf_pkg::LTMF_WAKE)),
    .expired(wake_filtered)
  );

  ////////////////////////////////////////////////////////////////////////
  // Wake detection

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wake_armed_r <= 1'b0;
      bus_prev_r <= 1'b1;
    end else if (clk_en) begin
      bus_prev_r <= lin_bus_line;
      if (wake_filtered) begin
        wake_armed_r <= 1'b1;
      end else if (mode_r != ltmf_pkg::LTMF_WAKE || lin_bus_line) begin
        wake_armed_r <= 1'b0;
      end
    end
  end

  // locked after a wake until re-armed by host
  assign wake_event = (mode_r == ltmf_pkg::LTMF_WAKE) && wake_armed_r &&
                      !bus_prev_r && lin_bus_line && !wake_lock_r;

  ////////////////////////////////////////////////////////////////////////
  // Mode selection

  always_comb begin
    mode_nxt = mode_r;
    case (chip_mode)
      ltmf_pkg::LTMF_CHIP_INIT: begin
        mode_nxt = ltmf_pkg::LTMF_OFF;
      end
      ltmf_pkg::LTMF_CHIP_FAILSAFE: begin
        mode_nxt = ltmf_pkg::LTMF_WAKE;
      end
      ltmf_pkg::LTMF_CHIP_FLASH: begin
        // flash chip mode selects flash transceiver mode
        mode_nxt = ltmf_pkg::LTMF_FLASH;
      end
      ltmf_pkg::LTMF_CHIP_NORMAL: begin
        if (cmd_valid) begin
          case (cmd_code)
            ltmf_pkg::CMD_OFF: mode_nxt = ltmf_pkg::LTMF_OFF;
            ltmf_pkg::CMD_WAKE: mode_nxt = wake_lock_r ? mode_r :
                                           ltmf_pkg::LTMF_WAKE;
            ltmf_pkg::CMD_NORMAL: mode_nxt = ltmf_pkg::LTMF_NORMAL;
            ltmf_pkg::CMD_RXONLY: mode_nxt = ltmf_pkg::LTMF_RXONLY;
            default: mode_nxt = mode_r;
          endcase
        end else if (mode_r == ltmf_pkg::LTMF_FLASH) begin
          mode_nxt = ltmf_pkg::LTMF_NORMAL;
        end
        if (fault_any && !cmd_normal &&
            mode_nxt == ltmf_pkg::LTMF_NORMAL) begin
          mode_nxt = ltmf_pkg::LTMF_RXONLY;
        end
      end
      ltmf_pkg::LTMF_CHIP_SLEEP, ltmf_pkg::LTMF_CHIP_RESTART,
      ltmf_pkg::LTMF_CHIP_STOP: begin
        if (cmd_valid && cmd_code == ltmf_pkg::CMD_OFF &&
            chip_mode != ltmf_pkg::LTMF_CHIP_RESTART) begin
          mode_nxt = ltmf_pkg::LTMF_OFF;
        end else if (cmd_valid && cmd_code == ltmf_pkg::CMD_WAKE &&
                     !wake_lock_r) begin
          mode_nxt = ltmf_pkg::LTMF_WAKE;
        end
        if (mode_nxt != ltmf_pkg::LTMF_OFF &&
            mode_nxt != ltmf_pkg::LTMF_WAKE) begin
          mode_nxt = ltmf_pkg::LTMF_OFF;
        end
      end
      default: mode_nxt = mode_r;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_r <= ltmf_pkg::LTMF_OFF;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
    end
  end

  // wake lock cleared by normal, receive-only or off
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wake_lock_r <= 1'b0;
    end else if (clk_en) begin
      if (wake_event) begin
        wake_lock_r <= 1'b1;
      end else if (mode_r == ltmf_pkg::LTMF_NORMAL ||
                   mode_r == ltmf_pkg::LTMF_RXONLY ||
                   mode_r == ltmf_pkg::LTMF_OFF) begin
        wake_lock_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slope

  // shared slope, low by default, normal chip mode only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slope_r <= 1'b0;
    end else if (clk_en) begin
      if (slope_cmd_valid && chip_mode == ltmf_pkg::LTMF_CHIP_NORMAL) begin
        slope_r <= slope_normal_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake flags

  // flag set wins over clear; receive pulled low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wake_flag_r <= 1'b0;
      wake_rxd_low_r <= 1'b0;
    end else if (clk_en) begin
      if (wake_event) begin
        wake_flag_r <= 1'b1;
      end else if (wake_flag_clear) begin
        wake_flag_r <= 1'b0;
      end
      if (wake_event) begin
        wake_rxd_low_r <= 1'b1;
      end else if (mode_r != ltmf_pkg::LTMF_WAKE) begin
        wake_rxd_low_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Faults

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_to_r <= 1'b0;
      bus_fault_r <= 1'b0;
      short_r <= 1'b0;
    end else if (clk_en) begin
      if (tx_expired) begin
        tx_to_r <= 1'b1;
      end else if (cmd_normal) begin
        tx_to_r <= 1'b0;
      end
      if (bus_expired) begin
        bus_fault_r <= 1'b1;
      end else if (bus_fault_clear || cmd_normal) begin
        bus_fault_r <= 1'b0;
      end
      // receive low on a settled recessive bus; skips receive lag
      if (!drive_r && !txd_in && !rxd_r && lin_bus_line && bus_prev_r) begin
        short_r <= 1'b1;
      end else if (short_fault_clear || cmd_normal) begin
        short_r <= 1'b0;
      end
    end
  end

  // over-temperature block, released on transmit rising edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ot_block_r <= 1'b0;
      txd_prev_r <= 1'b1;
    end else if (clk_en) begin
      txd_prev_r <= txd_in;
      if (over_temp) begin
        ot_block_r <= 1'b1;
      end else if (!txd_prev_r && txd_in) begin
        ot_block_r <= 1'b0;
      end
    end
  end

  assign fault_any = tx_to_r || bus_fault_r || short_r;

  assign tx_allowed = (mode_r == ltmf_pkg::LTMF_NORMAL ||
                       mode_r == ltmf_pkg::LTMF_FLASH) &&
                      !fault_any && !ot_block_r && !over_temp;

  ////////////////////////////////////////////////////////////////////////
  // Pin outputs

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      drive_r <= 1'b0;
      rxd_r <= 1'b1;
      int_n_r <= 1'b1;
    end else if (clk_en) begin
      drive_r <= tx_allowed && !txd_in;
      if (wake_rxd_low_r || wake_event) begin
        rxd_r <= 1'b0;
      end else if (mode_r == ltmf_pkg::LTMF_OFF ||
                   mode_r == ltmf_pkg::LTMF_WAKE) begin
        rxd_r <= 1'b1;
      end else begin
        rxd_r <= lin_bus_line;
      end
      // interrupt unless masked; no wake interrupt from sleep or restart
      int_n_r <= !((wake_flag_r && !wake_irq_mask &&
                    (chip_mode == ltmf_pkg::LTMF_CHIP_STOP ||
                     chip_mode == ltmf_pkg::LTMF_CHIP_NORMAL)) ||
                   (bus_fault_r && !bus_fault_irq_mask));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      read_data_r <= 8'h00;
    end else if (clk_en) begin
      if (spi_read_addr == ltmf_pkg::WAKE_REG_ADDR) begin
        read_data_r <= {7'h00, wake_flag_r};
      end else begin
        read_data_r <= 8'h00;
      end
    end
  end

  assign rxd_out = rxd_r;
  assign int_n = int_n_r;
  assign bus_drive_dominant = drive_r;
  // pull-up off in wake and off modes
  assign pullup_en = (mode_r != ltmf_pkg::LTMF_OFF) &&
                     (mode_r != ltmf_pkg::LTMF_WAKE);
  assign slope_normal = slope_r;
  assign slope_ctrl_off = (mode_r == ltmf_pkg::LTMF_FLASH);
  // restart only from sleep; stop stays
  assign restart_req = wake_event && (chip_mode == ltmf_pkg::LTMF_CHIP_SLEEP);
  assign lin_mode = mode_r;
  assign lin_wake_flag = wake_flag_r;
  assign bus_fault_flag = bus_fault_r;
  assign short_fault_flag = short_r;
  assign tx_timeout_flag = tx_to_r;
  assign spi_read_data = read_data_r;

endmodule : ltmf_cell

// ### ltmf_cell_sva.sv
/*
  Checker for the LIN mode and fault cell, bound to the cell's ports.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module ltmf_cell_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Inputs watched
  input wire logic [2:0] chip_mode,
  input wire logic slope_cmd_valid,
  input wire logic txd_in,
  // Outputs watched
  input wire logic [2:0] lin_mode,
  input wire logic pullup_en,
  input wire logic bus_drive_dominant,
  input wire logic slope_normal,
  input wire logic slope_ctrl_off,
  input wire logic restart_req,
  input wire logic bus_fault_flag,
  input wire logic tx_timeout_flag,
  input wire logic lin_wake_flag,
  input wire logic rxd_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_reset_off: assert property (
    $rose(rst_n) |-> lin_mode == ltmf_pkg::LTMF_OFF && !slope_normal)
    else $error("mode or slope not cleared by reset");
  a_pullup_off: assert property (
    lin_mode == ltmf_pkg::LTMF_OFF || lin_mode == ltmf_pkg::LTMF_WAKE
    |-> !pullup_en)
    else $error("pull-up on in off or wake mode");
  a_init_forces: assert property (
    (chip_mode == ltmf_pkg::LTMF_CHIP_INIT) [*2]
    |-> lin_mode == ltmf_pkg::LTMF_OFF)
    else $error("init chip mode left cell on");
  a_fsafe_wake: assert property (
    (chip_mode == ltmf_pkg::LTMF_CHIP_FAILSAFE) [*2]
    |-> lin_mode == ltmf_pkg::LTMF_WAKE)
    else $error("fail-safe did not force wake mode");
  a_flash_only: assert property (
    slope_ctrl_off |-> lin_mode == ltmf_pkg::LTMF_FLASH
    && $past(chip_mode) == ltmf_pkg::LTMF_CHIP_FLASH)
    else $error("slope control off outside flash");
  a_slope_gate: assert property (
    $rose(slope_normal) |-> $past(slope_cmd_valid)
    && $past(chip_mode) == ltmf_pkg::LTMF_CHIP_NORMAL)
    else $error("slope changed without command in normal");
  a_drive_cause: assert property (
    bus_drive_dominant |-> !$past(txd_in))
    else $error("bus driven without dominant transmit");
  a_txto_cut: assert property (
    tx_timeout_flag && $past(tx_timeout_flag) |-> !bus_drive_dominant)
    else $error("bus driven after transmit time-out");
  a_fault_rxonly: assert property (
    $rose(bus_fault_flag) && $past(lin_mode) == ltmf_pkg::LTMF_NORMAL
    |=> lin_mode == ltmf_pkg::LTMF_RXONLY)
    else $error("bus fault did not force receive-only");
  a_restart_sleep: assert property (
    restart_req |-> (chip_mode == ltmf_pkg::LTMF_CHIP_SLEEP
    && lin_mode == ltmf_pkg::LTMF_WAKE) ##1 (lin_wake_flag && !rxd_out))
    else $error("restart request without a sleep wake");
endmodule : ltmf_cell_sva

// ### ltmf_host.sv
/*
  Host protocol controller model: drives the transmit pin.
  Assumes the bench calls send_level just after a rising edge.
*/
`timescale 1ns/100ps
module ltmf_host (
  // Clock
  input wire logic clk_sys,
  // Transmit pin, recessive high
  output logic txd_in
);
  initial txd_in = 1'b1;
  task automatic send_level(input logic lvl, input int n);
    txd_in <= lvl;
    repeat (n) @(posedge clk_sys);
  endtask : send_level
endmodule : ltmf_host

// ### ltmf_pkg.sv
/*
  Package for the LIN transceiver mode and fault control cell: mode
  encodings, chip-mode encodings, SPI command codes and timing counts.
  Assumes a 100 MHz internal clock.
*/
package ltmf_pkg;

  localparam int CLK_MHZ = 100;

  // Times in microseconds; counts derived at the clock rate
  localparam int TX_TIMEOUT_US = 300;
  localparam int BUS_TIMEOUT_US = 300;
  localparam int WAKE_FILTER_US = 30;
  localparam int TX_TIMEOUT_CYC = TX_TIMEOUT_US * CLK_MHZ;
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * CLK_MHZ;
  localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // Wake interrupt register address
  localparam logic [2:0] WAKE_REG_ADDR = 3'h0;

  // Transceiver modes, Gray coded along off-wake-normal-rxonly
  typedef enum logic [2:0] {
    LTMF_OFF = 3'h0,
    LTMF_WAKE = 3'h1,
    LTMF_NORMAL = 3'h3,
    LTMF_RXONLY = 3'h2,
    LTMF_FLASH = 3'h6
  } ltmf_mode_e;

  // Chip modes as seen by the cell
  typedef enum logic [2:0] {
    LTMF_CHIP_INIT = 3'h0,
    LTMF_CHIP_NORMAL = 3'h1,
    LTMF_CHIP_SLEEP = 3'h2,
    LTMF_CHIP_RESTART = 3'h3,
    LTMF_CHIP_STOP = 3'h4,
    LTMF_CHIP_FAILSAFE = 3'h5,
    LTMF_CHIP_FLASH = 3'h6
  } ltmf_chip_e;

  // Transceiver commands carried by the SPI decoder
  localparam logic [2:0] CMD_OFF = 3'h0;
  localparam logic [2:0] CMD_WAKE = 3'h1;
  localparam logic [2:0] CMD_NORMAL = 3'h2;
  localparam logic [2:0] CMD_RXONLY = 3'h3;

endpackage : ltmf_pkg

// ### ltmf_timer.sv
/*
  Level duration timer: counts cycles while a level is active and
  flags when the count reaches the limit, where it holds. Restarts on the opposite level.
  Assumes a synchronous active-low reset and a clock enable.
*/
`timescale 1ns/100ps
module ltmf_timer #(
  parameter int LIMIT = 100
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Level in, expiry out
  input wire logic level_active,
  output logic expired
);

  logic [ltmf_pkg::CNT_W-1:0] count_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (clk_en) begin
      if (!level_active) begin
        count_r <= '0;
      end else if (count_r != ltmf_pkg::CNT_W'(LIMIT)) begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  assign expired = level_active && (count_r == ltmf_pkg::CNT_W'(LIMIT));

endmodule : ltmf_timer

// ### testbench.sv
/*
  Self-checking bench for the LIN mode and fault cell.
  Assumes the cell, its package, host model and checker are compiled.
*/
`timescale 1ns/100ps
module testbench;
  logic clk_sys, rst_n, clk_en, cmd_valid, slope_cmd_valid, over_temp;
  logic slope_normal_sel, wake_flag_clear, bus_fault_clear, other_dom;
  logic short_fault_clear, wake_irq_mask, bus_fault_irq_mask, txd_in;
  logic [2:0] chip_mode, cmd_code, spi_read_addr, lin_mode;
  logic lin_bus_line, rxd_out, int_n, bus_drive_dominant, pullup_en;
  logic slope_normal, slope_ctrl_off, restart_req, lin_wake_flag;
  logic bus_fault_flag, short_fault_flag, tx_timeout_flag;
  logic [7:0] spi_read_data;
  logic [13:0] exp_q[$];
  logic [13:0] msk_q[$];
  logic [15:0] lfsr = 16'h5B51;
  int error_cnt = 0;
  int check_count = 0;
  localparam logic [13:0] MM = 14'h3800, MP = 14'h0400, MD = 14'h0200;
  localparam logic [13:0] MR = 14'h0100, MI = 14'h0080, MW = 14'h0040;
  localparam logic [13:0] MB = 14'h0020, MT = 14'h0008, MN = 14'h0004;
  localparam logic [13:0] MF = 14'h0002, MQ = 14'h0001, MS = 14'h0010;
  // Bus wired-AND: other node or cell pulls dominant
  assign lin_bus_line = !bus_drive_dominant && !other_dom;
  ltmf_cell i_ltmf_cell (
    .clk_sys, .rst_n, .clk_en, .chip_mode, .cmd_valid, .cmd_code,
    .slope_cmd_valid, .slope_normal_sel, .wake_flag_clear,
    .bus_fault_clear, .short_fault_clear, .wake_irq_mask,
    .bus_fault_irq_mask, .spi_read_addr, .txd_in, .lin_bus_line,
    .over_temp, .rxd_out, .int_n, .bus_drive_dominant, .pullup_en,
    .slope_normal, .slope_ctrl_off, .restart_req, .lin_mode,
    .lin_wake_flag, .bus_fault_flag, .short_fault_flag,
    .tx_timeout_flag, .spi_read_data
  );
  ltmf_host i_ltmf_host (
    .clk_sys,
    .txd_in
  );
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Oldest note compared against the settled outputs
  always @(negedge clk_sys) begin
    if (exp_q.size() > 0) begin
      chk({lin_mode, pullup_en, bus_drive_dominant, rxd_out, int_n,
        lin_wake_flag, bus_fault_flag, short_fault_flag, tx_timeout_flag,
        slope_normal, slope_ctrl_off, spi_read_data[0]} & msk_q.pop_front(),
        exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [13:0] seen, input logic [13:0] want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic conclude;
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic look(input logic [13:0] m, input logic [13:0] v);
    msk_q.push_back(m);
    exp_q.push_back(v & m);
    @(posedge clk_sys);
  endtask : look
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic chip(input logic [2:0] c);
    chip_mode <= c;
    cyc(3);
  endtask : chip
  task automatic cmd(input logic [2:0] k);
    cmd_valid <= 1'b1;
    cmd_code <= k;
    cyc(1);
    cmd_valid <= 1'b0;
    cyc(1);
  endtask : cmd
  task automatic slope(input logic s);
    slope_cmd_valid <= 1'b1;
    slope_normal_sel <= s;
    cyc(1);
    slope_cmd_valid <= 1'b0;
    cyc(1);
  endtask : slope
  task automatic clr;
    {wake_flag_clear, bus_fault_clear, short_fault_clear} <= 3'h7;
    cyc(1);
    {wake_flag_clear, bus_fault_clear, short_fault_clear} <= 3'h0;
    cyc(2);
  endtask : clr
  task automatic tx(input logic l, input int n);
    i_ltmf_host.send_level(l, n);
  endtask : tx
  task automatic wait_restart;
    int n;
    n = 0;
    while (restart_req !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      conclude();
    end
    @(posedge clk_sys);
  endtask : wait_restart
  function automatic logic [13:0] mv(input logic [2:0] m);
    return {m, 11'h000};
  endfunction : mv
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, chip_mode, cmd_valid, cmd_code, slope_cmd_valid} = '0;
    {slope_normal_sel, wake_flag_clear, bus_fault_clear} = '0;
    {short_fault_clear, wake_irq_mask, bus_fault_irq_mask} = '0;
    {spi_read_addr, over_temp, other_dom} = '0;
    clk_en = 1'b1;
    cyc(4);
    rst_n <= 1'b1;
    look(MM | MP | MD | MR | MI | MW | MN | MF, MR | MI);
    for (int c = 1; c <= 4; c++) begin
      chip(c[2:0]);
      cmd(ltmf_pkg::CMD_OFF);
      look(MM, 14'h0000);
      cmd(ltmf_pkg::CMD_NORMAL);
      look(MM, mv(c == 1 ? 3'h3 : 3'h0));
      cmd(ltmf_pkg::CMD_RXONLY);
      look(MM, mv(c == 1 ? 3'h2 : 3'h0));
      cmd(ltmf_pkg::CMD_WAKE);
      look(MM | MP, mv(3'h1));
      cmd(ltmf_pkg::CMD_OFF);
    end
    chip(3'h1);
    cmd(ltmf_pkg::CMD_NORMAL);
    chip(3'h0);
    look(MM, 14'h0000);
    chip(3'h5);
    look(MM | MP, mv(3'h1));
    chip(3'h6);
    look(MF, MF);
    chip(3'h1);
    slope(1'b1);
    look(MN | MF, MN);
    chip(3'h4);
    slope(1'b0);
    look(MN, MN);
    chip(3'h1);
    slope(1'b0);
    cmd(ltmf_pkg::CMD_NORMAL);
    look(MM | MP | MN, mv(3'h3) | MP);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      tx(lfsr[0], 3);
      look(MD | MR, lfsr[0] ? MR : MD);
    end
    tx(1'b1, 3);
    cmd(ltmf_pkg::CMD_RXONLY);
    other_dom <= 1'b1;
    tx(1'b0, 3);
    look(MD | MR, 14'h0000);
    other_dom <= 1'b0;
    tx(1'b1, 3);
    // Wake armed by its own command before the sleep request
    cmd(ltmf_pkg::CMD_WAKE);
    chip(3'h2);
    other_dom <= 1'b1;
    cyc(3500);
    look(MW, 14'h0000);
    other_dom <= 1'b0;
    wait_restart();
    look(MR | MI | MW, MI | MW);
    look(MQ, MQ);
    spi_read_addr <= 3'h5;
    cyc(1);
    look(MQ, 14'h0000);
    spi_read_addr <= 3'h0;
    for (int m = 0; m < 2; m++) begin
      chip(3'h1);
      clr();
      cmd(ltmf_pkg::CMD_OFF);
      cmd(ltmf_pkg::CMD_WAKE);
      look(MM, mv(3'h1));
      wake_irq_mask <= m[0];
      chip(3'h4);
      other_dom <= 1'b1;
      cyc(3200);
      other_dom <= 1'b0;
      cyc(6);
      look(MM | MR | MI | MW, mv(3'h1) | MW | (m == 1 ? MI : 14'h0));
    end
    chip(3'h1);
    clr();
    cmd(ltmf_pkg::CMD_NORMAL);
    other_dom <= 1'b1;
    cyc(30100);
    look(MM | MB | MI | MR | MD, mv(3'h2) | MB);
    other_dom <= 1'b0;
    cyc(3);
    look(MR, MR);
    clr();
    cmd(ltmf_pkg::CMD_NORMAL);
    look(MM | MB, mv(3'h3));
    tx(1'b0, 30100);
    look(MD | MT, MT);
    tx(1'b1, 3);
    cmd(ltmf_pkg::CMD_NORMAL);
    clr();
    tx(1'b0, 3);
    look(MM | MT | MD, mv(3'h3) | MD);
    over_temp <= 1'b1;
    cyc(3);
    look(MD | MB | MT | MI | MS, MI);
    over_temp <= 1'b0;
    cyc(3);
    look(MD, 14'h0000);
    tx(1'b1, 3);
    tx(1'b0, 3);
    look(MD, MD);
    tx(1'b1, 3);
    cyc(3);
    conclude();
  end
endmodule : testbench

bind ltmf_cell ltmf_cell_sva i_sva (
  .clk_sys, .rst_n, .chip_mode, .slope_cmd_valid, .txd_in, .lin_mode,
  .pullup_en, .bus_drive_dominant, .slope_normal, .slope_ctrl_off,
  .restart_req, .bus_fault_flag, .tx_timeout_flag, .lin_wake_flag,
  .rxd_out
);
